// [pofs_pkg.sv]
// Constants and state types for the on/off, fault clear and store command block
package pofs_pkg;
	// Command codes
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_POLICY = 8'h02;
	localparam logic [7:0] CMD_CLEAR = 8'h03;
	localparam logic [7:0] CMD_STORE = 8'h15;
	localparam logic [7:0] CMD_FAULTS = 8'h78;
	// Reset values of the switch policy and operation bytes, writable mask of the switch policy byte
	localparam logic [7:0] POLICY_RESET = 8'h17;
	localparam logic [7:0] POLICY_MASK = 8'h1F;
	localparam logic [7:0] OPER_RESET = 8'h00;
	// Field positions of the switch policy byte
	localparam int POL_IMMED = 0;
	localparam int POL_EN_POL = 1;
	localparam int POL_USE_EN = 2;
	localparam int POL_USE_OP = 3;
	localparam int POL_GATED = 4;
	// Field positions of the operation byte
	localparam int OP_ON = 7;
	localparam int OP_MARGIN_HI = 5;
	localparam int OP_MARGIN_LO = 4;
	// Bus address, arbitrary neutral value
	localparam logic [6:0] DEV_ADDR_RESET = 7'h2A;
	// Bit counter marks within one byte slot
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_ACK_DONE = 4'h9;
	// Store busy time
	localparam int CLK_HZ = 50_000_000;
	localparam int STORE_BUSY_MS = 100;
	localparam int STORE_BUSY_CYCLES = STORE_BUSY_MS * (CLK_HZ / 1000);
	// Bus slave states
	typedef enum logic [4:0] {
		BUS_IDLE = 5'b0_0001,
		BUS_ADDR = 5'b0_0010,
		BUS_CMD = 5'b0_0100,
		BUS_WDATA = 5'b0_1000,
		BUS_RDATA = 5'b1_0000
	} pofs_bus_t;
	// Output power states
	typedef enum logic [2:0] {
		PWR_OFF = 3'b001,
		PWR_ON = 3'b010,
		PWR_RAMP = 3'b100
	} pofs_pwr_t;
endpackage

// [pofs_ctrl.sv]
// Command handling for output switch policy, fault clear and user store
`timescale 1ns/1ps
module pofs_ctrl
	import pofs_pkg::*;
#(
	parameter int FAULT_W = 8,
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_RESET,
	parameter int BUSY_CYCLES = STORE_BUSY_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic pmb_clk_i,
	input wire logic pmb_dat_i,
	output logic pmb_dat_o,
	output logic pmb_dat_oe,
	input wire logic en_pin_i,
	input wire logic [FAULT_W-1:0] fault_cond_i,
	input wire logic shutdown_req_i,
	input wire logic ramp_done_i,
	output logic alert_line_o,
	output logic alert_line_oe,
	output logic out_run,
	output logic pwm_tristate,
	output logic soft_off,
	output logic [1:0] margin_sel,
	output logic store_pulse,
	output logic store_busy,
	output logic [7:0] user_policy,
	output logic [7:0] user_oper
);
	localparam int SYN_W = FAULT_W + 4;
	localparam int CNT_W = $clog2(BUSY_CYCLES + 1);
	// Decode helpers shared by the command and data slots
	function automatic logic cmd_known(input logic [7:0] c);
		cmd_known = (c == CMD_OPERATION) || (c == CMD_POLICY) || (c == CMD_CLEAR) ||
			(c == CMD_STORE) || (c == CMD_FAULTS);
	endfunction
	function automatic logic cmd_writable(input logic [7:0] c);
		cmd_writable = (c == CMD_OPERATION) || (c == CMD_POLICY);
	endfunction
	logic [SYN_W-1:0] syn1_ff, syn2_ff;
	logic scl_d_ff, sda_d_ff, busy_out_ff;
	pofs_bus_t bus_ff;
	pofs_pwr_t pwr_ff, nxt_pwr;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff, tx_ff, cmd_ff, policy_ff, oper_ff, user_policy_ff, user_oper_ff;
	logic [1:0] pend_ff;
	logic sda_oe_ff, low_ff, alert_oe_ff, run_ff, tri_ff, soft_ff, store_ff, latched_ff;
	logic [FAULT_W-1:0] fault_ff, nxt_fault;
	logic [CNT_W-1:0] busy_ff;

	// Pins cross in through two flops; only the second stage is read
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			syn1_ff <= SYN_W'(2'b11); // Bus pins idle high, so no false edge
			syn2_ff <= SYN_W'(2'b11);
		end else if (ce) begin
			syn1_ff <= {shutdown_req_i, fault_cond_i, en_pin_i, pmb_dat_i, pmb_clk_i};
			syn2_ff <= syn1_ff;
		end
	end

	wire scl_s = syn2_ff[0];
	wire sda_s = syn2_ff[1];
	wire en_s = syn2_ff[2]; // High means asserted
	wire [FAULT_W-1:0] fault_s = syn2_ff[FAULT_W+2:3];
	wire shut_s = syn2_ff[SYN_W-1];
	// Previous sampled levels for edge and start/stop detection
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else if (ce) begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	// Bus events and byte decode
	wire scl_rise = scl_s & ~scl_d_ff;
	wire scl_fall = ~scl_s & scl_d_ff;
	wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	wire busy = (busy_ff != '0);
	wire addr_hit = (shift_ff[7:1] == DEV_ADDR) & ~busy; // Stay deaf while storing
	wire slot_end = scl_fall & (bit_ff == BIT_ACK);
	wire data_wr = ce & slot_end & (bus_ff == BUS_WDATA) & cmd_writable(cmd_ff);
	wire clr_pulse = ce & stop_det & pend_ff[0]; // Runs only on a byte-free frame
	wire store_go = ce & stop_det & pend_ff[1];
	wire [7:0] rd_data = (cmd_ff == CMD_OPERATION) ? oper_ff :
		(cmd_ff == CMD_POLICY) ? policy_ff :
		(cmd_ff == CMD_FAULTS) ? 8'(fault_ff) : 8'h00;

	// Bus slave: shift on rising edges, drive data and acknowledge on falling edges
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			bus_ff <= BUS_IDLE;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			cmd_ff <= 8'h00;
			pend_ff <= 2'b00;
			sda_oe_ff <= 1'b0;
		end else if (ce) begin
			if (start_det) begin
				bus_ff <= BUS_ADDR;
				bit_ff <= 4'h0;
				sda_oe_ff <= 1'b0;
				pend_ff <= 2'b00;
			end else if (stop_det) begin
				bus_ff <= BUS_IDLE;
				sda_oe_ff <= 1'b0;
				pend_ff <= 2'b00;
			end else if (bus_ff != BUS_IDLE && scl_rise) begin
				if (bit_ff < BIT_ACK) begin
					shift_ff <= {shift_ff[6:0], sda_s};
					bit_ff <= bit_ff + 4'h1;
					if (bus_ff == BUS_RDATA) begin
						tx_ff <= {tx_ff[6:0], 1'b0};
					end
				end else begin
					bit_ff <= BIT_ACK_DONE;
					if (bus_ff == BUS_RDATA) begin
						if (sda_s) begin
							bus_ff <= BUS_IDLE;
						end else begin
							tx_ff <= rd_data;
						end
					end
				end
			end else if (bus_ff != BUS_IDLE && scl_fall) begin
				if (bit_ff == BIT_ACK) begin
					case (bus_ff)
						BUS_ADDR: begin
							sda_oe_ff <= addr_hit;
							tx_ff <= rd_data;
							bus_ff <= !addr_hit ? BUS_IDLE : (shift_ff[0] ? BUS_RDATA : BUS_CMD);
						end
						BUS_CMD: begin
							sda_oe_ff <= cmd_known(shift_ff);
							cmd_ff <= shift_ff;
							pend_ff <= {shift_ff == CMD_STORE, shift_ff == CMD_CLEAR};
							bus_ff <= cmd_known(shift_ff) ? BUS_WDATA : BUS_IDLE;
						end
						BUS_WDATA: begin
							// Data after a send-byte code cancels it
							sda_oe_ff <= cmd_writable(cmd_ff);
							pend_ff <= 2'b00;
							if (!cmd_writable(cmd_ff)) begin
								bus_ff <= BUS_IDLE;
							end
						end
						default: begin
							sda_oe_ff <= 1'b0;
						end
					endcase
				end else if (bit_ff == BIT_ACK_DONE) begin
					bit_ff <= 4'h0;
					sda_oe_ff <= (bus_ff == BUS_RDATA) & ~tx_ff[7];
				end else begin
					sda_oe_ff <= (bus_ff == BUS_RDATA) & ~tx_ff[7];
				end
			end
		end
	end

	// Settings registers; unused policy bits never stored
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			policy_ff <= POLICY_RESET;
			oper_ff <= OPER_RESET;
		end else if (data_wr) begin
			if (cmd_ff == CMD_POLICY) begin
				policy_ff <= shift_ff & POLICY_MASK;
			end else begin
				oper_ff <= shift_ff;
			end
		end
	end

	// User store snapshot and busy timer; the host keeps the output off meanwhile
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			user_policy_ff <= POLICY_RESET;
			user_oper_ff <= OPER_RESET;
			store_ff <= 1'b0;
			busy_ff <= '0;
			busy_out_ff <= 1'b0;
		end else if (ce) begin
			store_ff <= store_go;
			busy_out_ff <= store_go | (busy && (busy_ff != CNT_W'(1))); // Busy flag from a flop
			if (store_go) begin
				user_policy_ff <= policy_ff;
				user_oper_ff <= oper_ff;
				busy_ff <= CNT_W'(BUSY_CYCLES);
			end else if (busy) begin
				busy_ff <= busy_ff - CNT_W'(1);
			end
		end
	end

	// Sticky faults: a live condition beats the clear in the same cycle
	assign nxt_fault = fault_s | (fault_ff & ~{FAULT_W{clr_pulse}});
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			fault_ff <= '0;
			alert_oe_ff <= 1'b0;
		end else if (ce) begin
			fault_ff <= nxt_fault;
			alert_oe_ff <= |nxt_fault; // Released by the clear
		end
	end

	// On request from policy, pin and command on bit
	wire use_op = policy_ff[POL_USE_OP];
	wire use_en = policy_ff[POL_USE_EN];
	wire want_on = ~policy_ff[POL_GATED] |
		((~use_op | oper_ff[OP_ON]) &
		(~use_en | en_s));
	wire immed = policy_ff[POL_IMMED];
	// Shutdown latch; cleared only by dropping the on request, never by fault clear
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			latched_ff <= 1'b0;
		end else if (ce) begin
			latched_ff <= shut_s | (latched_ff & want_on);
		end
	end

	// Power state; a shutdown always takes the immediate path
	always_comb begin
		nxt_pwr = pwr_ff;
		case (pwr_ff)
			PWR_OFF: begin
				if (want_on && !latched_ff && !shut_s) begin
					nxt_pwr = PWR_ON;
				end
			end
			PWR_ON: begin
				if (latched_ff || shut_s) begin
					nxt_pwr = PWR_OFF;
				end else if (!want_on) begin
					nxt_pwr = immed ? PWR_OFF : PWR_RAMP;
				end
			end
			PWR_RAMP: begin
				if (ramp_done_i || latched_ff) begin
					nxt_pwr = PWR_OFF;
				end
			end
			default: begin
				nxt_pwr = PWR_OFF;
			end
		endcase
	end

	// Stage outputs registered from the next state, so off takes effect at once
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pwr_ff <= PWR_OFF;
			run_ff <= 1'b0;
			tri_ff <= 1'b1;
			soft_ff <= 1'b0;
			low_ff <= 1'b0;
		end else if (ce) begin
			pwr_ff <= nxt_pwr;
			run_ff <= (nxt_pwr == PWR_ON);
			tri_ff <= (nxt_pwr == PWR_OFF);
			soft_ff <= (nxt_pwr == PWR_RAMP);
			low_ff <= 1'b0;
		end
	end

	// Port drive
	assign pmb_dat_o = low_ff;
	assign pmb_dat_oe = sda_oe_ff;
	assign alert_line_o = low_ff;
	assign alert_line_oe = alert_oe_ff;
	assign out_run = run_ff;
	assign pwm_tristate = tri_ff;
	assign soft_off = soft_ff;
	assign margin_sel = oper_ff[OP_MARGIN_HI:OP_MARGIN_LO];
	assign store_pulse = store_ff;
	assign store_busy = busy_out_ff;
	assign user_policy = user_policy_ff;
	assign user_oper = user_oper_ff;

	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	immed_off_a: assert property (ce && pwr_ff == PWR_ON && !want_on && immed
		|=> pwm_tristate && !soft_off && !out_run) else $error("immediate off missed");
	gated_on_a: assert property (ce && pwr_ff == PWR_OFF && !want_on
		|=> !out_run) else $error("output started without request");
	drop_off_a: assert property (ce && out_run && use_op && use_en && policy_ff[POL_GATED]
		&& (!en_s || !oper_ff[OP_ON]) |=> !out_run) else $error("output stayed on");
	always_on_a: assert property (ce && !policy_ff[POL_GATED] && pwr_ff == PWR_OFF
		&& !latched_ff && !shut_s |=> out_run) else $error("ungated device not on");
	soft_off_a: assert property (ce && pwr_ff == PWR_ON && !want_on && !immed
		&& !latched_ff && !shut_s |=> soft_off ##0 !pwm_tristate) else $error("soft off missed");
	reset_cfg_a: assert property (disable iff (1'b0) !rst_b |=> policy_ff == POLICY_RESET)
		else $error("policy reset value wrong");
	high_zero_a: assert property (policy_ff[7:5] == 3'b000)
		else $error("unused policy bits set");
	clear_alert_a: assert property (clr_pulse && fault_s == '0
		|=> !alert_line_oe && fault_ff == '0) else $error("alert not released");
	refault_a: assert property (ce && fault_s != '0 |=> alert_line_oe)
		else $error("live fault not flagged");
	no_restart_a: assert property (clr_pulse && latched_ff && want_on
		|=> !out_run) else $error("clear restarted output");
	busy_deaf_a: assert property (busy && $past(busy) |-> !pmb_dat_oe)
		else $error("bus answered while storing");
	store_copy_a: assert property (store_go |=> user_policy == $past(policy_ff)
		&& store_busy) else $error("store snapshot wrong");
endmodule // pofs_ctrl

// [pofs_host.sv]
// Behavioural bus host that bit-bangs clock and open-drain data
`timescale 1ns/1ps
module pofs_host #(
	parameter int HALF_NS = 400,
	parameter logic [6:0] ADDR = 7'h2A
) (
	output logic pmb_clk,
	output logic dat_pull,
	input wire logic dat_line
);
	localparam int Q = HALF_NS / 2;
	// Idle: clock high, data released; clock only toggles inside frames
	initial begin
		pmb_clk = 1'b1;
		dat_pull = 1'b0;
	end
	// Data falls while clock high; also serves as repeated start
	task automatic start_cond();
		#Q dat_pull = 1'b0;
		#Q pmb_clk = 1'b1;
		#HALF_NS dat_pull = 1'b1;
		#HALF_NS pmb_clk = 1'b0;
	endtask
	task automatic stop_cond();
		#Q dat_pull = 1'b1;
		#Q pmb_clk = 1'b1;
		#HALF_NS dat_pull = 1'b0;
		#HALF_NS;
	endtask
	// Data changes mid low phase, sampled mid high phase
	task automatic xfer_bit(input logic b, output logic r);
		#Q dat_pull = !b;
		#Q pmb_clk = 1'b1;
		#Q r = dat_line;
		#Q pmb_clk = 1'b0;
	endtask
	// MSB first; ninth slot released, so a read byte ends with no acknowledge
	task automatic xfer_byte(input logic [7:0] d, output logic [7:0] r, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], b);
			r[i] = b;
		end
		xfer_bit(1'b1, b);
		ack = !b;
	endtask
	// Write or send-byte; ok only if every byte was acknowledged
	task automatic write_cmd(input logic [7:0] c, input logic [7:0] d, input logic has_d,
		output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		start_cond();
		xfer_byte({ADDR, 1'b0}, r, a0);
		xfer_byte(c, r, a1);
		a2 = 1'b1;
		if (has_d) xfer_byte(d, r, a2);
		stop_cond();
		ok = a0 && a1 && a2;
	endtask
	task automatic read_cmd(input logic [7:0] c, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2, na;
		start_cond();
		xfer_byte({ADDR, 1'b0}, r, a0);
		xfer_byte(c, r, a1);
		start_cond();
		xfer_byte({ADDR, 1'b1}, r, a2);
		xfer_byte(8'hFF, d, na);
		stop_cond();
		ok = a0 && a1 && a2;
	endtask
endmodule // pofs_host

// [tb.sv]
// Self-checking bench for the on/off, fault clear and store block
`timescale 1ns/1ps
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module tb;
	import pofs_pkg::*;
	localparam int BUSY = 2000;
	logic clock = 1'b0, rst_b = 1'b0, ce = 1'b1, en = 1'b0, shut = 1'b0, rdone = 1'b0;
	logic dat_o, alert_o, alert_line_b;
	logic [7:0] faults = 8'h00;
	logic hclk, hpull, dat_line, dat_oe, alert_oe, out_run, pwm_tri, soft_off, spulse, sbusy, ok;
	logic [1:0] margin;
	logic [7:0] upol, uop, rd;
	int n_errors = 0, tests_run = 0, n_pulses = 0;
	always #10 clock = ~clock;
	// Open-drain data and alert with pull-ups; the slave's drive value counts
	assign dat_line = hpull ? 1'b0 : (dat_oe ? dat_o : 1'b1);
	assign alert_line_b = alert_oe ? alert_o : 1'b1;
	// Counted mid-cycle, away from the edge that launches the pulse
	always @(negedge clock) if (spulse === 1'b1) n_pulses++;
	pofs_ctrl #(.BUSY_CYCLES(BUSY)) pofs_ctrl_i (.clock(clock), .rst_b(rst_b), .ce(ce),
		.pmb_clk_i(hclk), .pmb_dat_i(dat_line), .pmb_dat_o(dat_o), .pmb_dat_oe(dat_oe),
		.en_pin_i(en), .fault_cond_i(faults), .shutdown_req_i(shut), .ramp_done_i(rdone),
		.alert_line_o(alert_o), .alert_line_oe(alert_oe), .out_run(out_run),
		.pwm_tristate(pwm_tri), .soft_off(soft_off), .margin_sel(margin),
		.store_pulse(spulse), .store_busy(sbusy), .user_policy(upol), .user_oper(uop));
	// 160 ns bus clock: four system clocks per phase cover the sync delay
	pofs_host #(.HALF_NS(80), .ADDR(DEV_ADDR_RESET)) pofs_host_i (.pmb_clk(hclk),
		.dat_pull(hpull), .dat_line(dat_line));
	task automatic settle();
		repeat (8) @(negedge clock);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic hd);
		pofs_host_i.write_cmd(c, d, hd, ok);
		settle();
	endtask
	task automatic rdc(input logic [7:0] c, input logic [7:0] e, input string m);
		pofs_host_i.read_cmd(c, rd, ok);
		`CHK(ok, 1'b1, m)
		`CHK(rd, e, m)
	endtask
	// Pins change at the falling edge, then the synchronisers settle
	task automatic pins(input logic e, input logic [7:0] f, input logic s, input logic r);
		@(negedge clock);
		en = e;
		faults = f;
		shut = s;
		rdone = r;
		settle();
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run of about 0.15 ms
	initial begin
		#600_000;
		n_errors++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		tally_and_finish();
	end
	initial begin
		repeat (16) @(negedge clock);
		rst_b = 1'b1;
		repeat (4) @(negedge clock);
		`CHK(pwm_tri, 1'b1, "tristate at reset")
		rdc(CMD_POLICY, POLICY_RESET, "policy reset");
		rdc(CMD_OPERATION, OPER_RESET, "oper reset");
		pins(1'b1, 8'h00, 1'b0, 1'b0);
		`CHK(out_run, 1'b1, "pin high starts")
		pins(1'b0, 8'h00, 1'b0, 1'b0);
		`CHK({out_run, soft_off, pwm_tri}, 3'b001, "immediate off")
		$display("test reset_and_pin done");
		wr(CMD_POLICY, 8'hFF, 1'b1);
		rdc(CMD_POLICY, 8'h1F, "unused bits");
		pins(1'b1, 8'h00, 1'b0, 1'b0);
		`CHK(out_run, 1'b0, "pin alone")
		wr(CMD_OPERATION, 8'hA0, 1'b1);
		`CHK({out_run, margin}, 3'b110, "pin and command")
		pins(1'b0, 8'h00, 1'b0, 1'b0);
		`CHK(out_run, 1'b0, "pin drop")
		pins(1'b1, 8'h00, 1'b0, 1'b0);
		wr(CMD_OPERATION, 8'h10, 1'b1);
		`CHK({out_run, margin}, 3'b001, "command drop")
		$display("test both_gates done");
		wr(CMD_POLICY, 8'h18, 1'b1);
		pins(1'b0, 8'h00, 1'b0, 1'b0);
		wr(CMD_OPERATION, 8'h80, 1'b1);
		`CHK(out_run, 1'b1, "command only on")
		wr(CMD_OPERATION, 8'h00, 1'b1);
		`CHK(soft_off, 1'b1, "soft off ramps")
		pins(1'b0, 8'h00, 1'b0, 1'b1);
		`CHK({soft_off, pwm_tri}, 2'b01, "ramp ends")
		wr(CMD_POLICY, 8'h07, 1'b1);
		`CHK(out_run, 1'b1, "always on")
		$display("test policy_modes done");
		wr(CMD_POLICY, POLICY_RESET, 1'b1);
		pins(1'b0, 8'h05, 1'b0, 1'b0);
		pins(1'b0, 8'h01, 1'b0, 1'b0);
		rdc(CMD_FAULTS, 8'h05, "faults latched");
		wr(CMD_CLEAR, 8'h00, 1'b0);
		rdc(CMD_FAULTS, 8'h01, "fault persists");
		`CHK({alert_oe, alert_line_b}, 2'b10, "alert held")
		pins(1'b0, 8'h00, 1'b0, 1'b0);
		wr(CMD_CLEAR, 8'h00, 1'b1);
		`CHK({ok, alert_oe}, 2'b01, "clear with data refused")
		wr(CMD_CLEAR, 8'h00, 1'b0);
		`CHK({ok, alert_oe, alert_line_b}, 3'b101, "alert released")
		pins(1'b1, 8'h00, 1'b1, 1'b0);
		pins(1'b1, 8'h00, 1'b0, 1'b0);
		wr(CMD_CLEAR, 8'h00, 1'b0);
		`CHK(out_run, 1'b0, "no restart")
		pins(1'b0, 8'h00, 1'b0, 1'b0);
		pins(1'b1, 8'h00, 1'b0, 1'b0);
		`CHK(out_run, 1'b1, "restart by pin")
		$display("test faults done");
		// Clock enable low freezes the pin path, so the drop waits for it
		@(negedge clock);
		ce = 1'b0;
		pins(1'b0, 8'h00, 1'b0, 1'b0);
		`CHK(out_run, 1'b1, "frozen by enable")
		@(negedge clock);
		ce = 1'b1;
		settle();
		`CHK(out_run, 1'b0, "pin drop after thaw")
		$display("test clock_enable done");
		pins(1'b0, 8'h00, 1'b0, 1'b0);
		wr(CMD_OPERATION, 8'h20, 1'b1);
		wr(CMD_STORE, 8'h00, 1'b0);
		`CHK({ok, upol, uop}, {1'b1, POLICY_RESET, 8'h20}, "store copies")
		pofs_host_i.read_cmd(CMD_POLICY, rd, ok);
		`CHK({ok, sbusy}, 2'b01, "busy ignores bus")
		repeat (BUSY) @(negedge clock);
		`CHK(sbusy, 1'b0, "busy ends")
		rdc(CMD_POLICY, POLICY_RESET, "bus back");
		`CHK(n_pulses, 1, "one store pulse")
		$display("test store done");
		tally_and_finish();
	end
endmodule // tb
